// ---- dv/reconfig_memory_safeguard_tb.sv ----
`timescale 1ns/1ps
`define chk(n,e,g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module reconfig_memory_safeguard_tb;
   import reload_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, user_ce;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, sweep_we, sweep_data, ram_ce, cycles_ff;
   logic [15:0] sweep_addr;
   int failures = 0;
   int comparisons = 0;
   int fz_n, sw_n;
   reload_if link();
   reload_host reload_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host),
      .sweep_we(sweep_we), .sweep_addr(sweep_addr), .sweep_data(sweep_data));
   reload_ctrl reload_ctrl_i (.pclk(pclk), .presetn(presetn),
      .link(link.ctrl), .user_ce(user_ce), .ram_ce(ram_ce),
      .cycles_ff(cycles_ff));
   reload_monitor reload_monitor_i (.pclk(pclk), .presetn(presetn),
      .reconfig_begin(link.reconfig_begin),
      .dual_cycle_request(link.dual_cycle_request), .freeze(link.freeze),
      .reload_done(link.reload_done), .region_clear(link.region_clear));
   initial
   begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      if (link.freeze === 1'b1)
      begin
         fz_n++;
         `chk("ram_ce frozen", 1'b0, ram_ce)
      end
      if (sweep_we === 1'b1)
      begin
         `chk("sweep addr", sw_n, sweep_addr)
         sw_n++;
         `chk("sweep data", 1'b1, sweep_data)
      end
   end
   task summarize;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // waits on pready, never assumes the one-cycle answer
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task t_reset;
      `chk("clear", 1'b1, link.region_clear)
      `chk("ram_ce", 1'b0, ram_ce)
      apb(1'b0, stat_off, 32'h0);
      `chk("stat clear", 1'b1, rd[clear_bit])
      `chk("stat busy", 1'b0, rd[busy_bit])
      apb(1'b0, ctrl_off, 32'h0);
      `chk("ctrl", ctrl_rst, rd)
      apb(1'b0, sweep_words_off, 32'h0);
      `chk("words", sweep_words_rst, rd[15:0])
      apb(1'b1, 8'h3c, 32'hffff_ffff);
      `chk("unmapped err", 1'b1, err)
      apb(1'b0, 8'h3c, 32'h0);
      `chk("unmapped data", 32'h0, rd)
      apb(1'b1, ctrl_off, 32'h1 << clear_rel_bit);
      repeat (2) @(posedge pclk);
      `chk("clear released", 1'b0, link.region_clear)
      $display("test reset done");
   endtask
   task reload(input logic dual, input logic ov, input logic [31:0] words);
      int exp_fz;
      exp_fz = dual ? 2 * freeze_cycles + gap_cycles + 1 : freeze_cycles + 1;
      apb(1'b1, sweep_words_off, words);
      fz_n = 0;
      sw_n = 0;
      apb(1'b1, ctrl_off, (32'h1 << go_bit) | (32'(dual) << dual_bit)
         | (32'(ov) << overwrite_bit));
      while (link.reload_done !== 1'b1)
         @(posedge pclk);
      repeat (8) @(posedge pclk);
      `chk("freeze len", exp_fz, fz_n)
      `chk("cycles", !dual, cycles_ff)
      `chk("sweep words", ov ? 0 : int'(words), sw_n)
      `chk("clear end", 1'b0, link.region_clear)
      `chk("dual end", 1'b0, link.dual_cycle_request)
      `chk("ram_ce end", 1'b1, ram_ce)
      $display("test reload dual %0d overwrite %0d done", dual, ov);
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      failures++;
      summarize;
   end
   initial
   begin
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 8'h00;
      pwdata = 32'h0;
      user_ce = 1;
      presetn = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      reload(1'b0, 1'b0, 32'h3);
      reload(1'b1, 1'b0, 32'h2);
      reload(1'b1, 1'b1, 32'h4);
      reload(1'b0, 1'b1, 32'h1);
      summarize;
   end
endmodule

// ---- dv/reload_monitor.sv ----
`timescale 1ns/1ps
module reload_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic reconfig_begin,
   input wire logic dual_cycle_request,
   input wire logic freeze,
   input wire logic reload_done,
   input wire logic region_clear
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_hold8;
      freeze [*8];
   endsequence
   property p_dual_rise;
      $rose(dual_cycle_request) |-> reconfig_begin;
   endproperty
   a_dual_rise: assert property (p_dual_rise)
      else $error("dual request rose without begin");
   property p_start;
      reconfig_begin |=> freeze;
   endproperty
   a_start: assert property (p_start)
      else $error("freeze did not follow begin");
   property p_single;
      reconfig_begin && !dual_cycle_request |=> s_hold8;
   endproperty
   a_single: assert property (p_single)
      else $error("single freeze too short");
   // two 8-cycle freeze holds back to back, 16 cycles in all, gap not counted
   property p_dual;
      reconfig_begin && dual_cycle_request |=> s_hold8 ##1 s_hold8;
   endproperty
   a_dual: assert property (p_dual)
      else $error("dual freeze too short");
   property p_bound;
      reconfig_begin |-> ##[10:30] !freeze;
   endproperty
   a_bound: assert property (p_bound)
      else $error("freeze never ended");
   property p_dual_hold;
      $fell(dual_cycle_request) |-> !freeze && $fell(region_clear);
   endproperty
   a_dual_hold: assert property (p_dual_hold)
      else $error("dual request dropped early");
   property p_clear_last;
      $fell(region_clear) |-> !freeze && !dual_cycle_request;
   endproperty
   a_clear_last: assert property (p_clear_last)
      else $error("clear released too early");
   property p_frozen_clear;
      freeze || reconfig_begin |-> region_clear;
   endproperty
   a_frozen_clear: assert property (p_frozen_clear)
      else $error("clear low while frozen");
endmodule

// ---- rtl/ram_ce_gate.sv ----
`timescale 1ns/1ps
module ram_ce_gate
   import reload_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic region_clear,
   input wire logic user_ce,
   output logic ram_ce
);
   logic ce_ff;
   // the static clear is made on this clock, so it needs no synchroniser;
   // the raw term below blocks the strobe in the very cycle clear rises
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ce_ff <= 1'b0;
      else
         ce_ff <= user_ce & ~region_clear;
   end
   assign ram_ce = ce_ff & ~region_clear;
endmodule

// ---- rtl/reload_ctrl.sv ----
`timescale 1ns/1ps
module reload_ctrl
   import reload_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   reload_if.ctrl link,
   input wire logic user_ce,
   output logic ram_ce,
   output logic cycles_ff
);
   typedef enum logic [2:0] {c_idle, c_freeze1, c_gap, c_freeze2,
      c_done} cstate_t;
   cstate_t state_ff;
   logic dual_ff;
   logic [3:0] cnt_ff;
   logic freeze_ff;
   logic done_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_ff <= c_idle;
         dual_ff <= 1'b0;
         cnt_ff <= 4'h0;
         freeze_ff <= 1'b0;
         done_ff <= 1'b0;
         cycles_ff <= 1'b0;
      end
      else
      begin
         done_ff <= 1'b0;
         unique case (state_ff)
            c_idle:
               if (link.reconfig_begin)
               begin
                  dual_ff <= link.dual_cycle_request;
                  cnt_ff <= freeze_cnt_init;
                  freeze_ff <= 1'b1;
                  cycles_ff <= 1'b0;
                  state_ff <= c_freeze1;
               end
            c_freeze1:
               if (cnt_ff == 4'h1)
               begin
                  cycles_ff <= 1'b1;
                  if (dual_ff)
                  begin
                     cnt_ff <= gap_cnt_init;
                     state_ff <= c_gap;
                  end
                  else
                     state_ff <= c_done;
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            c_gap:
               if (cnt_ff == 4'h1)
               begin
                  cnt_ff <= freeze_cnt_init;
                  state_ff <= c_freeze2;
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            c_freeze2:
               if (cnt_ff == 4'h1)
               begin
                  cycles_ff <= 1'b0;
                  state_ff <= c_done;
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            c_done:
            begin
               freeze_ff <= 1'b0;
               done_ff <= 1'b1;
               state_ff <= c_idle;
            end
            default: state_ff <= c_idle;
         endcase
      end
   end
   assign link.freeze = freeze_ff;
   assign link.reload_done = done_ff;
   ram_ce_gate u_gate
   (
      .pclk(pclk),
      .presetn(presetn),
      .region_clear(link.region_clear),
      .user_ce(user_ce),
      .ram_ce(ram_ce)
   );
endmodule

// ---- rtl/reload_host.sv ----
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - non-overwrite mode: write ones everywhere first
// - no stray memory write on entry
// - enable gate sits beside each ram
// - gate cleared from static side, active high
// - clear frozen before reload starts
// - clear released only as final step; the code also releases it on an explicit release while idle
// - initialised ram: two back-to-back cycles
// - controller takes dual-cycle request input
// - controller times gap between cycles
// - dual request rises with begin request
// - hold dual request until freeze drops
// - works with compressed or encrypted streams
module reload_host
   import reload_pkg::*;
#(
   parameter int sweep_aw = 16
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   reload_if.host link,
   output logic sweep_we,
   output logic [sweep_aw-1:0] sweep_addr,
   output logic sweep_data
);
   typedef enum logic [2:0] {h_idle, h_sweep, h_clear, h_start, h_wait,
      h_release} hstate_t;
   hstate_t state_ff;
   logic [31:0] ctrl_ff;
   logic [sweep_aw-1:0] words_ff;
   logic [sweep_aw-1:0] addr_ff;
   logic we_ff;
   logic begin_ff;
   logic dual_ff;
   logic clear_ff;
   logic done_ff;
   logic [31:0] rdata_ff;
   logic [sweep_aw-1:0] waddr_ff;
   logic data_ff;
   logic frz_seen;
   logic acc;
   logic wr;
   logic wr_ctrl;
   logic last_step;
   // one address compare, shared by write path and error flag; the read mux decodes paddr itself
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction
   function automatic logic mapped(input logic [7:0] a);
      return hit(a, ctrl_off) | hit(a, stat_off) | hit(a, sweep_words_off);
   endfunction
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign wr_ctrl = wr & hit(paddr, ctrl_off);
   // freeze is made on this clock, so it is taken as is; a synchroniser
   // here would only stretch the release
   assign frz_seen = link.freeze;
   assign last_step = state_ff == h_release && !frz_seen;
   // apb registers; slave answers in the access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_ff <= ctrl_rst;
         words_ff <= sweep_aw'(sweep_words_rst);
      end
      else
      begin
         if (wr_ctrl)
            ctrl_ff <= pwdata;
         else if (state_ff == h_sweep || state_ff == h_clear)
            ctrl_ff[go_bit] <= 1'b0;
         if (wr && hit(paddr, sweep_words_off))
            words_ff <= pwdata[sweep_aw-1:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rdata_ff <= 32'h0;
      else if (psel && !penable && !pwrite)
      begin
         rdata_ff <= 32'h0;
         unique case (paddr)
            ctrl_off: rdata_ff <= ctrl_ff;
            stat_off: rdata_ff <= {28'h0, link.reload_done | done_ff,
               clear_ff, frz_seen, state_ff != h_idle};
            sweep_words_off: rdata_ff <= 32'(words_ff);
            default: rdata_ff <= 32'h0;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped(paddr);
      end
   end
   assign prdata = rdata_ff;
   // reload sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_ff <= h_idle;
      else
      begin
         unique case (state_ff)
            h_idle:
               if (!ctrl_ff[clear_rel_bit] && ctrl_ff[go_bit])
                  state_ff <= ctrl_ff[overwrite_bit] ? h_clear : h_sweep;
            h_sweep:
               if (addr_ff == words_ff - 1'b1)
                  state_ff <= h_clear;
            h_clear:
               state_ff <= h_start;
            h_start:
               state_ff <= h_wait;
            h_wait:
               if (frz_seen)
                  state_ff <= h_release;
            h_release:
               if (!frz_seen)
                  state_ff <= h_idle;
            default: state_ff <= h_idle;
         endcase
      end
   end
   // sweep counter; the write port gets the address one cycle later,
   // beside its strobe, so location zero is written too
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         addr_ff <= '0;
      else if (state_ff == h_idle)
         addr_ff <= '0;
      else if (state_ff == h_sweep)
         addr_ff <= addr_ff + 1'b1;
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         we_ff <= 1'b0;
         waddr_ff <= '0;
         data_ff <= 1'b0;
      end
      else
      begin
         we_ff <= state_ff == h_sweep;
         waddr_ff <= addr_ff;
         data_ff <= state_ff == h_sweep;
      end
   end
   // begin is a one-cycle pulse; the dual request rises with it and is
   // held until the controller lets go of freeze
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         begin_ff <= 1'b0;
         dual_ff <= 1'b0;
      end
      else
      begin
         begin_ff <= state_ff == h_start;
         if (state_ff == h_start)
            dual_ff <= ctrl_ff[dual_bit];
         else if (last_step)
            dual_ff <= 1'b0;
      end
   end
   // clear is up from reset and before every begin, and drops only as the
   // very last step of a reload or on an explicit release while idle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clear_ff <= 1'b1;
      else if (state_ff == h_clear)
         clear_ff <= 1'b1;
      else if (last_step)
         clear_ff <= 1'b0;
      else if (state_ff == h_idle && ctrl_ff[clear_rel_bit])
         clear_ff <= 1'b0;
   end
   // a finishing reload wins over a control write in the same cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         done_ff <= 1'b0;
      else if (last_step)
         done_ff <= 1'b1;
      else if (wr_ctrl)
         done_ff <= 1'b0;
   end
   assign link.reconfig_begin = begin_ff;
   assign link.dual_cycle_request = dual_ff;
   assign link.region_clear = clear_ff;
   assign sweep_we = we_ff;
   assign sweep_addr = waddr_ff;
   assign sweep_data = data_ff;
endmodule

// ---- rtl/reload_if.sv ----
`timescale 1ns/1ps
interface reload_if;
   logic reconfig_begin;
   logic dual_cycle_request;
   logic freeze;
   logic reload_done;
   logic region_clear;
   modport host
   (
      output reconfig_begin,
      output dual_cycle_request,
      output region_clear,
      input freeze,
      input reload_done
   );
   modport ctrl
   (
      input reconfig_begin,
      input dual_cycle_request,
      input region_clear,
      output freeze,
      output reload_done
   );
endinterface

// ---- rtl/reload_pkg.sv ----
package reload_pkg;
   // control register offsets on the host apb slave
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] stat_off = 8'h04;
   localparam logic [7:0] sweep_words_off = 8'h08;
   // control register fields
   localparam int go_bit = 0;
   localparam int dual_bit = 1;
   localparam int overwrite_bit = 2;
   localparam int clear_rel_bit = 3;
   // status register fields; cycles_bit is not wired into the read data
   localparam int busy_bit = 0;
   localparam int freeze_bit = 1;
   localparam int clear_bit = 2;
   localparam int done_bit = 3;
   localparam int cycles_bit = 4;
   // reset values
   localparam logic [31:0] ctrl_rst = 32'h0000_0000;
   localparam logic [15:0] sweep_words_rst = 16'h0010;
   // cycle counts of the controller
   localparam int freeze_cycles = 8;
   localparam int gap_cycles = 4;
   localparam logic [3:0] freeze_cnt_init = 4'h8;
   localparam logic [3:0] gap_cnt_init = 4'h4;
   typedef enum logic [1:0] {op_none, op_single, op_dual} op_t;
endpackage
